//--- src/sfp_ctrl.sv
// Purpose: Flash self-programming controller behind an Avalon-MM slave
// Assumes: Pins pass two flops; core signals share mclk_i
// Notes:   rst_i is power-on reset; sys_reset_i is the soft system reset
//
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`include "sfp_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module sfp_ctrl #(
  parameter int           OP_CYCLES = `SFP_OP_CYCLES,
  parameter logic [7:0]   SIG0      = 8'h3B,  // Arbitrary value
  parameter logic [7:0]   SIG1      = 8'h6D,  // Arbitrary value
  parameter logic [7:0]   SIG2      = 8'h27,  // Arbitrary value
  parameter logic [7:0]   CAL       = 8'h80   // Arbitrary value
) (
  input  wire logic               mclk_i,
  input  wire logic               rst_i,
  input  wire logic [4:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic               global_ie_i,
  input  wire logic               eeprom_write_active_i,
  input  wire logic               sys_reset_i,
  input  wire logic [7:0]         fuse_low_byte_i,
  input  wire logic [7:0]         fuse_high_byte_i,
  input  wire logic [2:0]         extended_fuse_byte_i,
  input  wire logic [7:0]         flash_byte_i,
  output logic      [15:0]        flash_raddr_o,
  output var sfp_pkg::sfp_flash_s flash_o,
  output logic                    irq_o,
  output logic                    cpu_halt_o,
  output logic                    rww_read_block_o
);

  typedef struct packed {
    sfp_pkg::sfp_pins_s    sy1;
    sfp_pkg::sfp_pins_s    sy2;
    logic                  ee3;
    sfp_pkg::sfp_ctrl_s    ctrl;
    logic                  busy;
    logic [2:0]            win;
    sfp_pkg::sfp_op_e      op;
    sfp_pkg::sfp_kind_e    kind;
    logic [16:0]           cnt;
    logic [7:0]            page;
    logic [5:0]            lkdata;
    logic [15:0]           z;
    logic [15:0]           work;
    logic [5:0]            lock;
    logic [127:0][15:0]    mem;
    logic [127:0]          vld;
    logic                  wt;
    logic [31:0]           rdata;
    sfp_pkg::sfp_flash_s   fl;
    logic                  irq;
    logic                  halt;
    logic                  blk;
  } sfp_state_s;

  sfp_state_s q;
  sfp_state_s d;
  sfp_pkg::sfp_pins_s pins;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       ee_busy;
  logic [5:0] pat;
  logic       store_ok;
  logic       load_ok;
  logic [6:0] wsel;

  assign pins     = '{ee: eeprom_write_active_i, srst: sys_reset_i, fl: fuse_low_byte_i,
                      fh: fuse_high_byte_i, fe: extended_fuse_byte_i};
  assign acc      = (avs_read_i | avs_write_i) & ~q.wt;
  assign wr       = acc & avs_write_i;
  // Reads are answered as waitrequest falls, so the data stand while it is low
  assign rd       = avs_read_i & ~avs_write_i & q.wt;
  assign ee_busy  = q.sy2.ee;
  assign pat      = {q.ctrl.sig, q.ctrl.rww_reenable_bit, q.ctrl.lock, q.ctrl.page_write_bit, q.ctrl.page_erase_bit, q.ctrl.en};
  assign store_ok = (q.win != 3'h0) & q.ctrl.en & (q.op == sfp_pkg::SFP_IDLE);
  assign load_ok  = (q.win > (`SFP_STORE_WIN - `SFP_LOAD_WIN)) & q.ctrl.en;
  assign wsel     = q.z[`SFP_WORD_HI:`SFP_WORD_LO];

  always_comb begin
    d          = q;
    d.sy1      = pins;
    d.sy2      = q.sy1;
    d.ee3      = q.sy2.ee;
    d.wt       = ~((avs_read_i | avs_write_i) & q.wt);
    d.fl.erase = 1'b0;
    d.fl.wr    = 1'b0;
    if (q.win != 3'h0) begin
      d.win = q.win - 3'h1;
    end
    // Window ran out with no instruction: drop the armed command
    if (q.win == 3'h1 && q.op == sfp_pkg::SFP_IDLE) begin
      d.ctrl = '{ie: q.ctrl.ie, default: 1'b0};
    end
    // EEPROM write starting discards any loaded words
    if (q.sy2.ee && !q.ee3) begin
      d.vld = '0;
    end

    // Register writes
    if (wr) begin
      case (avs_address_i)
        `SFP_OFF_CTRL: begin
          d.ctrl.ie = avs_writedata_i[`SFP_B_IE];
          if (q.op == sfp_pkg::SFP_IDLE) begin
            d.ctrl.sig    = avs_writedata_i[`SFP_B_SIG];
            d.ctrl.rww_reenable_bit = avs_writedata_i[`SFP_B_RWW_REENABLE_BIT];
            d.ctrl.lock   = avs_writedata_i[`SFP_B_LOCK];
            d.ctrl.page_write_bit  = avs_writedata_i[`SFP_B_PAGE_WRITE_BIT];
            d.ctrl.page_erase_bit  = avs_writedata_i[`SFP_B_PAGE_ERASE_BIT];
            d.ctrl.en     = avs_writedata_i[`SFP_B_EN];
            d.win         = avs_writedata_i[`SFP_B_EN] ? `SFP_STORE_WIN : 3'h0;
            if (avs_writedata_i[`SFP_B_RWW_REENABLE_BIT]) begin
              d.vld = '0;
            end
          end
        end
        `SFP_OFF_PTR:  d.z    = avs_writedata_i[15:0];
        `SFP_OFF_WORK: d.work = avs_writedata_i[15:0];
        `SFP_OFF_STORE: begin
          d.win  = 3'h0;
          d.ctrl = '{ie: q.ctrl.ie, default: 1'b0};
          // EEPROM activity refuses every command
          if (store_ok && !ee_busy) begin
            case (pat)
              `SFP_P_LOAD: begin
                d.mem[wsel] = q.work;
                d.vld[wsel] = 1'b1;
              end
              `SFP_P_ERASE: begin
                d.ctrl.en    = 1'b1;
                d.ctrl.page_erase_bit = 1'b1;
                d.page       = q.z[`SFP_PAGE_HI:`SFP_PAGE_LO];
                d.kind       = sfp_pkg::SFP_K_ERASE;
                d.op         = sfp_pkg::SFP_TIMED;
                d.cnt        = 17'(OP_CYCLES - 1);
                d.busy       = 1'b1;
                d.fl.erase   = 1'b1;
                d.fl.page    = q.z[`SFP_PAGE_HI:`SFP_PAGE_LO];
              end
              `SFP_P_WRITE: begin
                d.ctrl.en    = 1'b1;
                d.ctrl.page_write_bit = 1'b1;
                d.page       = q.z[`SFP_PAGE_HI:`SFP_PAGE_LO];
                d.kind       = sfp_pkg::SFP_K_WRITE;
                d.op         = sfp_pkg::SFP_STREAM;
                d.cnt        = '0;
                d.busy       = 1'b1;
              end
              `SFP_P_LOCK: begin
                d.ctrl.en   = 1'b1;
                d.ctrl.lock = 1'b1;
                d.lkdata    = q.work[5:0];
                d.kind      = sfp_pkg::SFP_K_LOCK;
                d.op        = sfp_pkg::SFP_TIMED;
                d.cnt       = 17'(OP_CYCLES - 1);
              end
              `SFP_P_RWW_REENABLE_BIT: begin
                d.busy = 1'b0;
                d.vld  = '0;
              end
              default: begin
              end
            endcase
          end
        end
        default: begin
        end
      endcase
    end

    // Register reads; the load offset is the load-program instruction
    if (rd) begin
      d.rdata = '0;
      case (avs_address_i)
        `SFP_OFF_CTRL: d.rdata[7:0] = {q.ctrl.ie, q.busy, pat};
        `SFP_OFF_PTR:  d.rdata[15:0] = q.z;
        `SFP_OFF_WORK: d.rdata[15:0] = q.work;
        `SFP_OFF_LOAD: begin
          d.rdata[7:0] = flash_byte_i;
          if (load_ok && q.ctrl.lock && !ee_busy) begin
            case (q.z)
              16'h0000: d.rdata[7:0] = q.sy2.fl;
              16'h0001: d.rdata[7:0] = {2'b11, q.lock};
              16'h0002: d.rdata[7:0] = {5'h1F, q.sy2.fe};
              16'h0003: d.rdata[7:0] = q.sy2.fh;
              default:  d.rdata[7:0] = 8'hFF;
            endcase
          end else if (load_ok && q.ctrl.sig) begin
            case (q.z)
              16'h0000: d.rdata[7:0] = SIG0;
              16'h0001: d.rdata[7:0] = CAL;
              16'h0002: d.rdata[7:0] = SIG1;
              16'h0004: d.rdata[7:0] = SIG2;
              default:  d.rdata[7:0] = 8'hFF;
            endcase
          end
          if (load_ok && (q.ctrl.lock || q.ctrl.sig) && q.op == sfp_pkg::SFP_IDLE) begin
            d.ctrl = '{ie: q.ctrl.ie, default: 1'b0};
            d.win  = 3'h0;
          end
        end
        default: begin
        end
      endcase
    end

    // Operation sequencer
    case (q.op)
      sfp_pkg::SFP_STREAM: begin
        d.fl.wr   = 1'b1;
        d.fl.page = q.page;
        d.fl.word = q.cnt[6:0];
        d.fl.data = q.vld[q.cnt[6:0]] ? q.mem[q.cnt[6:0]] : `SFP_ERASED;
        d.cnt     = q.cnt + 17'h1;
        if (q.cnt[6:0] == `SFP_LAST_WORD) begin
          d.op  = sfp_pkg::SFP_TIMED;
          d.cnt = 17'(OP_CYCLES - 1);
        end
      end
      sfp_pkg::SFP_TIMED: begin
        d.cnt = q.cnt - 17'h1;
        if (q.cnt == 17'h0) begin
          d.op   = sfp_pkg::SFP_IDLE;
          d.ctrl = '{ie: q.ctrl.ie, default: 1'b0};
          if (q.kind == sfp_pkg::SFP_K_WRITE) begin
            d.vld = '0;
          end
          if (q.kind == sfp_pkg::SFP_K_LOCK) begin
            d.lock = q.lock & q.lkdata;
          end
        end
      end
      default: begin
      end
    endcase

    // Soft reset clears software state but lets a running operation end
    if (q.sy2.srst) begin
      d.vld = '0;
      if (q.op == sfp_pkg::SFP_IDLE) begin
        d.ctrl = '0;
        d.win  = 3'h0;
        d.busy = 1'b0;
      end
    end

    d.irq  = d.ctrl.ie & ~d.ctrl.en & global_ie_i;
    d.blk  = (d.op != sfp_pkg::SFP_IDLE) & (d.kind != sfp_pkg::SFP_K_LOCK);
    d.halt = d.blk & (d.page >= `SFP_NO_READ_WHILE_WRITE_SECTION_PAGE);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q        <= '0;
      q.wt     <= 1'b1;
      q.lock   <= `SFP_LOCK_RST;
      q.ctrl   <= sfp_pkg::sfp_ctrl_s'(7'(`SFP_CTRL_RST));
      q.op     <= sfp_pkg::SFP_IDLE;
      q.kind   <= sfp_pkg::SFP_K_ERASE;
    end else begin
      q <= d;
    end
  end

  assign avs_readdata_o    = q.rdata;
  assign avs_waitrequest_o = q.wt;
  assign flash_raddr_o     = q.z;
  assign flash_o           = q.fl;
  assign irq_o             = q.irq;
  assign cpu_halt_o        = q.halt;
  assign rww_read_block_o  = q.blk;

  // Checks
  a_en_during_op: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.op != sfp_pkg::SFP_IDLE |-> q.ctrl.en)
    else $error("enable bit low during operation");

  a_busy_during_op: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.blk |-> q.busy)
    else $error("busy flag low while section blocked");

  a_irq_level: assert property (@(posedge mclk_i) disable iff (rst_i)
    (q.ctrl.ie && !q.ctrl.en && global_ie_i && !acc && q.op == sfp_pkg::SFP_IDLE) |=> irq_o)
    else $error("interrupt request dropped");

  a_window_expiry: assert property (@(posedge mclk_i) disable iff (rst_i)
    (q.win == 3'h1 && q.op == sfp_pkg::SFP_IDLE && !acc) |=> !q.ctrl.en && !q.ctrl.lock)
    else $error("armed command survived its window");

  a_ee_refuse: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr && avs_address_i == `SFP_OFF_STORE && ee_busy && q.op == sfp_pkg::SFP_IDLE)
      |=> q.op == sfp_pkg::SFP_IDLE && !q.ctrl.en)
    else $error("command accepted during EEPROM write");

  a_write_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
    (q.op == sfp_pkg::SFP_TIMED && q.cnt == 17'h0 && q.kind == sfp_pkg::SFP_K_WRITE)
      |=> q.vld == '0 && !q.ctrl.en)
    else $error("buffer not cleared after page write");

  a_lock_readable: assert property (@(posedge mclk_i) disable iff (rst_i)
    q.kind == sfp_pkg::SFP_K_LOCK |-> !rww_read_block_o && !cpu_halt_o)
    else $error("flash blocked during lock programming");

  a_erase_start: assert property (@(posedge mclk_i) disable iff (rst_i)
    (wr && avs_address_i == `SFP_OFF_STORE && store_ok && !ee_busy && pat == `SFP_P_ERASE)
      |=> flash_o.erase ##1 !flash_o.erase && q.op == sfp_pkg::SFP_TIMED)
    else $error("erase did not start");

  a_stream_len: assert property (@(posedge mclk_i) disable iff (rst_i)
    $rose(q.op == sfp_pkg::SFP_STREAM) |-> ##128 q.op == sfp_pkg::SFP_TIMED)
    else $error("page write did not stream 128 words");

  c_page_write: cover property (@(posedge mclk_i) disable iff (rst_i)
    q.kind == sfp_pkg::SFP_K_WRITE && q.op == sfp_pkg::SFP_TIMED && q.cnt == 17'h0);
  c_lock_read: cover property (@(posedge mclk_i) disable iff (rst_i)
    rd && avs_address_i == `SFP_OFF_LOAD && load_ok && q.ctrl.lock);
  c_no_read_while_write_section_halt: cover property (@(posedge mclk_i) disable iff (rst_i) cpu_halt_o);

endmodule : sfp_ctrl

`default_nettype wire

//--- src/sfp_pkg.sv
// Purpose: Types for the self-programming controller
// Assumes: Included constants live in sfp_regs.svh
// Notes:   Types only
package sfp_pkg;

  typedef enum logic [1:0] {SFP_IDLE, SFP_STREAM, SFP_TIMED} sfp_op_e;
  typedef enum logic [1:0] {SFP_K_ERASE, SFP_K_WRITE, SFP_K_LOCK} sfp_kind_e;

  typedef struct packed {
    logic ie;
    logic sig;
    logic rww_reenable_bit;
    logic lock;
    logic page_write_bit;
    logic page_erase_bit;
    logic en;
  } sfp_ctrl_s;

  typedef struct packed {
    logic       ee;
    logic       srst;
    logic [7:0] fl;
    logic [7:0] fh;
    logic [2:0] fe;
  } sfp_pins_s;

  typedef struct packed {
    logic        erase;
    logic        wr;
    logic [7:0]  page;
    logic [6:0]  word;
    logic [15:0] data;
  } sfp_flash_s;

endpackage : sfp_pkg

//--- src/sfp_regs.svh
// Purpose: Register map, control patterns, reset values and timing counts
// Assumes: 25 MHz clock, 32-bit Avalon-MM word registers
// Notes:   Definitions only
`ifndef SFP_REGS_SVH
`define SFP_REGS_SVH

// Byte offsets
`define SFP_OFF_CTRL    5'h00
`define SFP_OFF_PTR     5'h04
`define SFP_OFF_WORK    5'h08
`define SFP_OFF_STORE   5'h0C
`define SFP_OFF_LOAD    5'h10

// Control bit positions
`define SFP_B_IE        7
`define SFP_B_BUSY      6
`define SFP_B_SIG       5
`define SFP_B_RWW_REENABLE_BIT    4
`define SFP_B_LOCK      3
`define SFP_B_PAGE_WRITE_BIT     2
`define SFP_B_PAGE_ERASE_BIT     1
`define SFP_B_EN        0

// Command patterns on control bits 5..0
`define SFP_P_LOAD      6'h01
`define SFP_P_ERASE     6'h03
`define SFP_P_WRITE     6'h05
`define SFP_P_LOCK      6'h09
`define SFP_P_RWW_REENABLE_BIT    6'h11
`define SFP_P_SIG       6'h21

// Pointer fields and sections
`define SFP_PAGE_HI     15
`define SFP_PAGE_LO     8
`define SFP_WORD_HI     7
`define SFP_WORD_LO     1
`define SFP_NO_READ_WHILE_WRITE_SECTION_PAGE   8'hE0
`define SFP_LAST_WORD   7'h7F

// Reset values
`define SFP_CTRL_RST    8'h00
`define SFP_LOCK_RST    6'h3F
`define SFP_ERASED      16'hFFFF

// Timing: store window, load window, operation length
`define SFP_STORE_WIN   3'h4
`define SFP_LOAD_WIN    3'h3
`define SFP_CLK_KHZ     25000
`define SFP_OP_MIN_US   3700
`define SFP_OP_MAX_US   4500
`define SFP_OP_CYCLES   ((`SFP_OP_MIN_US * `SFP_CLK_KHZ + 999) / 1000)

`endif

//--- verif/sfp_flash_model.sv
// Purpose: Behavioural flash array on the far side of the controller
// Assumes: Erase and write pulses last one cycle; byte 0 of a word at even address
// Notes:   Unwritten words hold a pattern made from their index
`timescale 1ns/100ps
`default_nettype none

module sfp_flash_model (
  input  wire  logic                mclk_i,
  input  wire  sfp_pkg::sfp_flash_s flash_i,
  input  wire  logic [15:0]         raddr_i,
  output logic [7:0]                byte_o
);
  logic [15:0] mem [int];
  logic [15:0] rw;

  function automatic logic [15:0] word_at(input logic [14:0] idx);
    if (mem.exists(int'(idx))) begin
      return mem[int'(idx)];
    end
    return {1'b0, idx} ^ 16'hA5A5;
  endfunction : word_at

  always @(posedge mclk_i) begin
    if (flash_i.erase) begin
      for (int w = 0; w < 128; w++) begin
        mem[int'({flash_i.page, w[6:0]})] = 16'hFFFF;
      end
    end
    if (flash_i.wr) begin
      mem[int'({flash_i.page, flash_i.word})] = flash_i.data;
    end
  end

  // Read data settle half a cycle before the controller samples them
  always @(negedge mclk_i) begin
    rw = word_at(raddr_i[15:1]);
    byte_o <= raddr_i[0] ? rw[15:8] : rw[7:0];
  end
endmodule : sfp_flash_model

`default_nettype wire

//--- verif/tb.sv
// Purpose: Self-checking bench for the self-programming controller
// Assumes: Short operation count; Avalon-MM access tasks
// Notes:   Flash array modelled by sfp_flash_model
`include "sfp_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module tb;
  localparam int         OPC      = 20;
  localparam logic [7:0] RD_CTL [7] = '{8'h09, 8'h09, 8'h09, 8'h21, 8'h21, 8'h21, 8'h21};
  localparam logic [7:0] RD_PTR [7] = '{8'h00, 8'h03, 8'h02, 8'h00, 8'h02, 8'h04, 8'h01};
  localparam logic [7:0] RD_EXP [7] = '{8'hA5, 8'h5A, 8'hFA, 8'hA1, 8'hB2, 8'hC3, 8'h5C};
  logic                mclk_i          = 1'b0;
  logic                rst_i           = 1'b1;
  logic [4:0]          avs_address_i   = 5'h00;
  logic                avs_read_i      = 1'b0;
  logic                avs_write_i     = 1'b0;
  logic [31:0]         avs_writedata_i = 32'h0;
  logic                global_ie_i     = 1'b0;
  logic                eeprom_write_active_i = 1'b0;
  logic                sys_reset_i     = 1'b0;
  logic [31:0]         avs_readdata_o;
  logic                avs_waitrequest_o;
  logic [7:0]          flash_byte_i;
  logic [15:0]         flash_raddr_o;
  sfp_pkg::sfp_flash_s flash_o;
  logic                irq_o;
  logic                cpu_halt_o;
  logic                rww_read_block_o;
  logic [31:0]         rq;
  logic [7:0]          fuse_lo;
  logic [7:0]          fuse_hi;
  logic [2:0]          fuse_ext;
  int                  num_errors      = 0;
  int                  cmp_count       = 0;

  always #20 mclk_i = ~mclk_i;

  // Signature and calibration values are arbitrary
  sfp_ctrl #(.OP_CYCLES(OPC), .SIG0(8'hA1), .SIG1(8'hB2), .SIG2(8'hC3), .CAL(8'h5C)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .global_ie_i(global_ie_i),
    .eeprom_write_active_i(eeprom_write_active_i), .sys_reset_i(sys_reset_i),
    .fuse_low_byte_i(fuse_lo), .fuse_high_byte_i(fuse_hi), .extended_fuse_byte_i(fuse_ext),
    .flash_byte_i(flash_byte_i), .flash_raddr_o(flash_raddr_o), .flash_o(flash_o), .irq_o(irq_o),
    .cpu_halt_o(cpu_halt_o), .rww_read_block_o(rww_read_block_o));

  sfp_flash_model flash_u (.mclk_i(mclk_i), .flash_i(flash_o), .raddr_i(flash_raddr_o), .byte_o(flash_byte_i));

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  // Request held until waitrequest is seen low, then released for one cycle
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address_i   <= a;
    avs_writedata_i <= d;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    do begin
      @(posedge mclk_i);
    end while (avs_waitrequest_o !== 1'b0);
    rq = avs_readdata_o;
    chk("waitrequest", 32'(avs_waitrequest_o), 32'h0);
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
    @(posedge mclk_i);
  endtask : bus

  task automatic cmd(input logic [7:0] c);
    bus(1'b1, `SFP_OFF_CTRL, {24'h0, c});
    bus(1'b1, `SFP_OFF_STORE, 32'h0);
  endtask : cmd

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, `SFP_OFF_CTRL, 32'h0);
      n++;
    end while (rq[0] !== 1'b0 && n < 400);
    chk("op_ends", 32'(rq[0]), 32'h0);
  endtask : wait_idle

  task automatic load_word(input logic [6:0] w, input logic [15:0] d);
    bus(1'b1, `SFP_OFF_PTR, {16'h0, 8'h00, w, 1'b0});
    bus(1'b1, `SFP_OFF_WORK, {16'h0, d});
    cmd(8'h01);
  endtask : load_word

  task automatic page_op(input logic [7:0] c, input logic [15:0] p);
    bus(1'b1, `SFP_OFF_PTR, {16'h0, p});
    cmd(c);
  endtask : page_op

  initial begin
    repeat (20000) @(posedge mclk_i);
    num_errors++;
    stop_test;
  end

  initial begin
    repeat (20) @(posedge mclk_i);
    rst_i    <= 1'b0;
    fuse_lo  <= 8'hA5;
    fuse_hi  <= 8'h5A;
    fuse_ext <= 3'b010;
    @(posedge mclk_i);
    bus(1'b0, `SFP_OFF_CTRL, 32'h0);
    chk("ctrl_reset", rq, 32'h0);
    bus(1'b1, 5'h14, 32'hFFFF_FFFF);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped", rq, 32'h0);
    $display("test reset done");
    global_ie_i <= 1'b1;
    load_word(7'h7F, 16'hBEEF);
    load_word(7'h00, 16'h1234);
    page_op(8'h85, 16'h1000);
    bus(1'b0, `SFP_OFF_CTRL, 32'h0);
    chk("ctrl_running", {24'h0, rq[7:0] & 8'h41}, 32'h41);
    chk("rww_block", 32'(rww_read_block_o), 32'h1);
    chk("no_halt", 32'(cpu_halt_o), 32'h0);
    chk("irq_busy", 32'(irq_o), 32'h0);
    wait_idle;
    chk("irq_done", 32'(irq_o), 32'h1);
    global_ie_i <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("irq_gated", 32'(irq_o), 32'h0);
    chk("word_last", 32'(flash_u.word_at({8'h10, 7'h7F})), 32'hBEEF);
    chk("word_first", 32'(flash_u.word_at({8'h10, 7'h00})), 32'h1234);
    chk("word_blank", 32'(flash_u.word_at({8'h10, 7'h05})), 32'hFFFF);
    bus(1'b0, `SFP_OFF_CTRL, 32'h0);
    chk("busy_held", 32'(rq[6]), 32'h1);
    cmd(8'h11);
    wait_idle;
    chk("busy_clear", 32'({rq[31:7], rq[6]}), 32'h0);
    chk("rww_open", 32'(rww_read_block_o), 32'h0);
    $display("test page write done");
    load_word(7'h03, 16'h5555);
    eeprom_write_active_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    page_op(8'h03, 16'h1100);
    chk("ee_refuse", 32'(rww_read_block_o), 32'h0);
    eeprom_write_active_i <= 1'b0;
    repeat (6) @(posedge mclk_i);
    page_op(8'h05, 16'h1100);
    wait_idle;
    chk("ee_discard", 32'(flash_u.word_at({8'h11, 7'h03})), 32'hFFFF);
    chk("buf_cleared", 32'(flash_u.word_at({8'h11, 7'h00})), 32'hFFFF);
    cmd(8'h11);
    wait_idle;
    $display("test buffer discard done");
    page_op(8'h03, 16'hE05B);
    chk("halt_no_read_while_write_section", 32'(cpu_halt_o), 32'h1);
    sys_reset_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    sys_reset_i <= 1'b0;
    repeat (5) @(posedge mclk_i);
    chk("op_survives", 32'(rww_read_block_o), 32'h1);
    wait_idle;
    chk("halt_end", 32'(cpu_halt_o), 32'h0);
    chk("erased", 32'(flash_u.word_at({8'hE0, 7'h2D})), 32'hFFFF);
    chk("other_page", 32'(flash_u.word_at({8'hE1, 7'h00})), 32'hD525);
    cmd(8'h11);
    wait_idle;
    $display("test erase done");
    bus(1'b1, `SFP_OFF_WORK, 32'h0000_00FC);
    cmd(8'h09);
    chk("lock_no_block", 32'(rww_read_block_o), 32'h0);
    wait_idle;
    bus(1'b1, `SFP_OFF_PTR, 32'h0001);
    bus(1'b1, `SFP_OFF_CTRL, 32'h09);
    bus(1'b0, `SFP_OFF_LOAD, 32'h0);
    chk("lock_read", rq, 32'hFC);
    bus(1'b0, `SFP_OFF_CTRL, 32'h0);
    chk("lock_clear", rq, 32'h0);
    bus(1'b1, `SFP_OFF_CTRL, 32'h09);
    repeat (6) @(posedge mclk_i);
    bus(1'b0, `SFP_OFF_CTRL, 32'h0);
    chk("window_lapse", rq, 32'h0);
    for (int i = 0; i < 7; i++) begin
      bus(1'b1, `SFP_OFF_PTR, {24'h0, RD_PTR[i]});
      bus(1'b1, `SFP_OFF_CTRL, {24'h0, RD_CTL[i]});
      bus(1'b0, `SFP_OFF_LOAD, 32'h0);
      chk("row_read", rq, {24'h0, RD_EXP[i]});
    end
    bus(1'b0, `SFP_OFF_CTRL, 32'h0);
    chk("sig_clear", rq, 32'h0);
    fuse_lo               <= 8'h3C;
    eeprom_write_active_i <= 1'b1;
    repeat (4) @(posedge mclk_i);
    bus(1'b1, `SFP_OFF_PTR, 32'h0);
    bus(1'b1, `SFP_OFF_CTRL, 32'h09);
    bus(1'b0, `SFP_OFF_LOAD, 32'h0);
    chk("fuse_refused", rq, 32'hA5);
    eeprom_write_active_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    bus(1'b1, `SFP_OFF_CTRL, 32'h09);
    bus(1'b0, `SFP_OFF_LOAD, 32'h0);
    chk("fuse_live", rq, 32'h3C);
    bus(1'b1, `SFP_OFF_PTR, 32'h0021);
    bus(1'b0, `SFP_OFF_LOAD, 32'h0);
    chk("plain_load", rq, 32'hA5);
    $display("test lock fuse signature done");
    stop_test;
  end
endmodule : tb

`default_nettype wire
